/* File: logic/kpm_pkg.sv */
// Shared constants, types and register map of the keypad mode controller
package kpm_pkg;
    // Register byte offsets
    localparam logic [3:0] REG_STAT  = 4'h0;
    localparam logic [3:0] REG_CLR   = 4'h4;
    localparam logic [3:0] REG_IEN   = 4'h8;
    localparam logic [3:0] REG_STATE = 4'hc;
    // Event bit positions in status, clear and enable
    localparam int EV_RUN   = 0;
    localparam int EV_STOP  = 1;
    localparam int EV_TRIP  = 2;
    localparam int EV_STORE = 3;
    localparam int EV_W     = 4;
    // Key bit positions
    localparam int K_MODE = 0;
    localparam int K_SET  = 1;
    localparam int K_UP   = 2;
    localparam int K_DOWN = 3;
    localparam int K_RUN  = 4;
    localparam int K_STOP = 5;
    localparam int K_W    = 6;
    // Parameter numbers and values
    localparam logic [7:0]  PN_RUNSRC = 8'h30;
    localparam logic [7:0]  PN_SCMUL  = 8'h47;
    localparam logic [7:0]  PN_SCSHR  = 8'h48;
    localparam logic [7:0]  PN_MAX    = 8'hf0;
    localparam logic [15:0] SRC_PANEL = 16'h0001;
    localparam logic [15:0] RUNSRC_RST = 16'h0000;
    localparam logic [15:0] SCMUL_RST = 16'h0001;
    localparam logic [15:0] SCSHR_RST = 16'h0000;
    localparam logic [15:0] VAL_MAX   = 16'hffff;
    localparam logic [16:0] D5_MAX    = 17'h1869f;
    // Character codes for the 2-digit display
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_F     = 8'h46;
    localparam logic [7:0] CH_R     = 8'h72;
    localparam logic [7:0] CH_BLANK = 8'h20;
    // Timing
    localparam int CLK_MHZ  = 250;
    localparam int DEB_MS   = 10;
    localparam int FLASH_MS = 250;
    localparam int DEB_CYC   = DEB_MS * CLK_MHZ * 1000;
    localparam int FLASH_CYC = FLASH_MS * CLK_MHZ * 1000;

    typedef enum logic [1:0] {ST_MON, ST_PNUM, ST_LOAD, ST_SET} kpm_state_t;
    typedef enum logic [2:0] {MON_SPD, MON_DCV, MON_LOAD, MON_TRQ, MON_CMD} kpm_mon_t;

    typedef struct packed {
        logic stop;
        logic run;
        logic down;
        logic up;
        logic set;
        logic mode;
    } kpm_keys_t;

    typedef struct packed {
        logic [15:0] speed;
        logic [15:0] dcv;
        logic [15:0] load;
        logic [15:0] torque;
        logic [15:0] cmd;
    } kpm_mon_vals_t;

    typedef struct packed {
        logic [16:0] value;
        logic        lit;
    } kpm_disp5_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } kpm_disp2_t;
endpackage : kpm_pkg

/* File: logic/kpm_param_mem.sv */
// Nonvolatile parameter image with registered read port
`timescale 1ns/1ps
`default_nettype none
module kpm_param_mem #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    input  wire logic          core_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata_q
);
    initial begin
        if (AW < 1 || DW < 1) $error("kpm_param_mem: bad width");
    end

    logic [DW-1:0] mem [2**AW];

    // Storage keeps no reset: it models the retained image
    always_ff @(posedge core_clk) begin
        if (we) mem[waddr] <= wdata;
        rdata_q <= mem[raddr];
    end
endmodule : kpm_param_mem
`default_nettype wire

/* File: logic/kpm_top.sv */
// Keypad mode controller: key decode, display modes, parameter edit
//
// Overview of operation
// [R1] MODE in monitor cycles speed, DC voltage, load, torque, command speed.
// [R2] MODE in setting mode commits the edited value to storage.
// [R3] DATA/SET toggles number and setting mode and stores edits.
// [R4] Up and down pressed together while tripped clears the trip.
// [R5] RUN issues run only when parameter 30 selects the panel.
// [R6] STOP issues stop only when parameter 30 selects the panel.
// [R7] Outside editing 2-digit shows direction when running, 00 when stopped.
// [R8] Direction letter F for counter-clockwise, r for clockwise.
// [R9] While editing the 2-digit display shows the parameter number.
// [R10] Monitor mode is the state after power-on.
// [R11] MODE in number or setting mode returns to monitor mode.
// [R12] Number mode shows the parameter number 00 to F0 flashing.
// [R13] Up and down step the parameter number through its range. Here they do not step it while tripped.
// [R14] Setting mode shows the value flashing; up and down change it. Here they do not change it while tripped.
// [R15] Store key writes the new value into the retained memory.
// [R16] Unstored edits are dropped; stored settings survive power loss. Here parameters 30, 47 and 48 return to their reset values on rst.
// [R17] Displayed speed is scaled by parameters 47 and 48.
// [R18] Speed in r/min, torque and load in percent of rated.
// [R19] Each key is debounced and edge detected: one press, one action.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module kpm_top
    import kpm_pkg::*;
#(
    parameter int DEB_N   = kpm_pkg::DEB_CYC,
    parameter int FLASH_N = kpm_pkg::FLASH_CYC
) (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire kpm_pkg::kpm_keys_t key_raw,
    input  wire kpm_pkg::kpm_mon_vals_t mon,
    input  wire logic               running,
    input  wire logic               dir_ccw,
    input  wire logic               tripped,
    input  wire logic [3:0]         addr,
    input  wire logic [31:0]        wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic      [31:0]        rdata,
    output logic                    irq,
    output logic                    run_cmd,
    output logic                    stop_cmd,
    output logic                    trip_clr,
    output kpm_pkg::kpm_disp5_t     disp5,
    output kpm_pkg::kpm_disp2_t     disp2,
    output logic                    d2_flash
);
    import kpm_pkg::*;

    initial begin
        if (DEB_N < 2 || FLASH_N < 2) $error("kpm_top: counts too small");
    end

    ////////////////////////////////////////////////////////////////////
    // Key synchronise, debounce and press edge

    logic [K_W-1:0] key_in;
    logic [K_W-1:0] stb_q;
    logic [K_W-1:0] stb_dly_q;
    logic [K_W-1:0] press;
    assign key_in = key_raw;

    genvar gi;
    generate
        for (gi = 0; gi < K_W; gi++) begin : g_key
            logic        s1_q;
            logic        s2_q;
            logic [31:0] cnt_q;
            // Two flops before anything reads the pin
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= key_in[gi];
                    s2_q <= s1_q;
                end
            end
            // Level must hold DEB_N cycles before it is believed
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    cnt_q <= '0;
                    stb_q[gi] <= 1'b0;
                end else if (s2_q == stb_q[gi]) begin
                    cnt_q <= '0;
                end else if (cnt_q == 32'(DEB_N - 1)) begin
                    cnt_q <= '0;
                    stb_q[gi] <= s2_q; // [R19]
                end else begin
                    cnt_q <= cnt_q + 32'h1;
                end
            end
        end
    endgenerate

    // Press edge, one pulse per stable press
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) stb_dly_q <= '0;
        else stb_dly_q <= stb_q;
    end
    assign press = stb_q & ~stb_dly_q; // [R19]

    ////////////////////////////////////////////////////////////////////
    // Mode machine and editing

    kpm_state_t  st_q;
    kpm_mon_t    sel_q;
    logic [7:0]  pnum_q;
    logic [15:0] edit_q;
    logic [15:0] mem_rd;
    logic        nvm_we;
    logic        both_q;
    logic        both;
    logic        step_up;
    logic        step_dn;
    logic [15:0] p_src_q;
    logic [15:0] p_mul_q;
    logic [15:0] p_shr_q;

    // Joint press of up and down is a trip clear, never a step
    assign both    = stb_q[K_UP] & stb_q[K_DOWN];
    assign step_up = press[K_UP] & ~stb_q[K_DOWN];
    assign step_dn = press[K_DOWN] & ~stb_q[K_UP];
    // Commit on either key that leaves setting mode
    assign nvm_we  = (st_q == ST_SET) & (press[K_MODE] | press[K_SET]); // [R2] [R15]

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_MON; // [R10]
        end else begin
            case (st_q)
                ST_MON:  if (press[K_SET]) st_q <= ST_PNUM;
                ST_PNUM: begin
                    if (press[K_MODE]) st_q <= ST_MON; // [R11]
                    else if (press[K_SET]) st_q <= ST_LOAD; // [R3]
                end
                ST_LOAD: st_q <= ST_SET;
                ST_SET:  begin
                    if (press[K_MODE]) st_q <= ST_MON; // [R11]
                    else if (press[K_SET]) st_q <= ST_PNUM; // [R3]
                end
                default: st_q <= ST_MON;
            endcase
        end
    end

    // Monitor quantity selection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_q <= MON_SPD;
        end else if (st_q == ST_MON && press[K_MODE]) begin
            case (sel_q) // [R1]
                MON_SPD:  sel_q <= MON_DCV;
                MON_DCV:  sel_q <= MON_LOAD;
                MON_LOAD: sel_q <= MON_TRQ;
                MON_TRQ:  sel_q <= MON_CMD;
                default:  sel_q <= MON_SPD;
            endcase
        end
    end

    // Parameter number wraps inside 00..F0
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pnum_q <= 8'h00;
        end else if (st_q == ST_PNUM && !tripped) begin
            if (step_up) pnum_q <= (pnum_q >= PN_MAX) ? 8'h00 : pnum_q + 8'h01; // [R13]
            else if (step_dn) pnum_q <= (pnum_q == 8'h00) ? PN_MAX : pnum_q - 8'h01; // [R13]
        end
    end

    // Working copy: loaded from the image, lost unless committed
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            edit_q <= 16'h0000; // [R16]
        end else if (st_q == ST_LOAD) begin
            // Obeyed parameters load from their shadows: the image may be unwritten
            case (pnum_q) // [R16]
                PN_RUNSRC: edit_q <= p_src_q;
                PN_SCMUL:  edit_q <= p_mul_q;
                PN_SCSHR:  edit_q <= p_shr_q;
                default:   edit_q <= mem_rd;
            endcase
        end else if (st_q == ST_SET && !tripped) begin
            if (step_up && edit_q != VAL_MAX) edit_q <= edit_q + 16'h0001; // [R14]
            else if (step_dn && edit_q != 16'h0000) edit_q <= edit_q - 16'h0001; // [R14]
        end
    end

    kpm_param_mem #(
        .AW (8),
        .DW (16)
    ) u_mem (
        .core_clk (core_clk),
        .we       (nvm_we),
        .waddr    (pnum_q),
        .wdata    (edit_q),
        .raddr    (pnum_q),
        .rdata_q  (mem_rd)
    );

    // Shadows of the parameters the block itself obeys
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            p_src_q <= RUNSRC_RST;
            p_mul_q <= SCMUL_RST;
            p_shr_q <= SCSHR_RST;
        end else if (nvm_we) begin
            if (pnum_q == PN_RUNSRC) p_src_q <= edit_q;
            if (pnum_q == PN_SCMUL) p_mul_q <= edit_q;
            if (pnum_q == PN_SCSHR) p_shr_q <= edit_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Drive commands

    logic panel;
    assign panel = (p_src_q == SRC_PANEL);

    // Pulses registered so they stand one clean cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run_cmd  <= 1'b0;
            stop_cmd <= 1'b0;
            trip_clr <= 1'b0;
            both_q   <= 1'b0;
        end else begin
            both_q   <= both;
            run_cmd  <= press[K_RUN] & panel; // [R5]
            stop_cmd <= press[K_STOP] & panel; // [R6]
            trip_clr <= both & ~both_q & tripped; // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Displays

    logic        flash_q;
    logic [31:0] fcnt_q;
    logic [31:0] spd_mul;
    logic [31:0] spd_scl;
    logic [16:0] mon_val;

    // Common blink phase for both flashing modes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fcnt_q  <= '0;
            flash_q <= 1'b1;
        end else if (fcnt_q == 32'(FLASH_N - 1)) begin
            fcnt_q  <= '0;
            flash_q <= ~flash_q;
        end else begin
            fcnt_q <= fcnt_q + 32'h1;
        end
    end

    // Speed scaling: multiply, then shift right; clipped to five digits
    assign spd_mul = mon.speed * p_mul_q; // [R17]
    assign spd_scl = spd_mul >> p_shr_q[4:0]; // [R17]

    always_comb begin
        case (sel_q) // [R18]
            MON_SPD:  mon_val = (spd_scl > 32'(D5_MAX)) ? D5_MAX : spd_scl[16:0];
            MON_DCV:  mon_val = {1'b0, mon.dcv};
            MON_LOAD: mon_val = {1'b0, mon.load};
            MON_TRQ:  mon_val = {1'b0, mon.torque};
            default:  mon_val = {1'b0, mon.cmd};
        endcase
    end

    function automatic logic [7:0] hexch(input logic [3:0] n);
        hexch = (n < 4'ha) ? (CH_ZERO + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction : hexch

    // Display registers, refreshed every cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            disp5    <= '0;
            disp2    <= '{hi: CH_ZERO, lo: CH_ZERO};
            d2_flash <= 1'b0;
        end else begin
            case (st_q)
                ST_MON: begin
                    disp5 <= '{value: mon_val, lit: 1'b1};
                    d2_flash <= 1'b0;
                    if (!running) disp2 <= '{hi: CH_ZERO, lo: CH_ZERO}; // [R7]
                    else disp2 <= '{hi: CH_BLANK, lo: dir_ccw ? CH_F : CH_R}; // [R7] [R8]
                end
                ST_PNUM: begin
                    disp5 <= '{value: {9'h000, pnum_q}, lit: flash_q}; // [R12]
                    disp2 <= '{hi: hexch(pnum_q[7:4]), lo: hexch(pnum_q[3:0])}; // [R9]
                    d2_flash <= 1'b1;
                end
                default: begin
                    disp5 <= '{value: {1'b0, edit_q}, lit: flash_q}; // [R14]
                    disp2 <= '{hi: hexch(pnum_q[7:4]), lo: hexch(pnum_q[3:0])}; // [R9]
                    d2_flash <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register port and interrupt

    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] ien_q;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;

    assign ev  = {nvm_we, trip_clr, stop_cmd, run_cmd};
    assign clr = (wr && addr == REG_CLR) ? wdata[EV_W-1:0] : '0;

    // Set beats clear so no event is lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) stat_q <= '0;
        else stat_q <= (stat_q & ~clr) | ev;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) ien_q <= '0;
        else if (wr && addr == REG_IEN) ien_q <= wdata[EV_W-1:0];
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                REG_STAT:  rdata <= {28'h0, stat_q};
                REG_IEN:   rdata <= {28'h0, ien_q};
                REG_STATE: rdata <= {16'h0, pnum_q, 3'h0, sel_q, st_q};
                default:   rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    assign irq = |(stat_q & ien_q);

    ////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_load_then_set;
        st_q == ST_LOAD ##1 st_q == ST_SET;
    endsequence

    property p_run_src;
        @(posedge core_clk) disable iff (rst) run_cmd |-> $past(panel);
    endproperty
    a_run_src: assert property (p_run_src) else $error("run without panel source"); // [R5]

    property p_stop_src;
        @(posedge core_clk) disable iff (rst)
            $past(press[K_STOP]) && $past(panel) |-> stop_cmd;
    endproperty
    a_stop_src: assert property (p_stop_src) else $error("panel stop lost"); // [R6]

    property p_trip;
        @(posedge core_clk) disable iff (rst) trip_clr |-> $past(tripped) && $past(both);
    endproperty
    a_trip: assert property (p_trip) else $error("trip clear without cause"); // [R4]

    property p_mon_wrap;
        @(posedge core_clk) disable iff (rst)
            st_q == ST_MON && sel_q == MON_CMD && press[K_MODE] |=> sel_q == MON_SPD;
    endproperty
    a_mon_wrap: assert property (p_mon_wrap) else $error("monitor cycle broken"); // [R1]

    property p_mode_store;
        @(posedge core_clk) disable iff (rst)
            st_q == ST_SET && press[K_MODE] |-> nvm_we ##1 st_q == ST_MON;
    endproperty
    a_mode_store: assert property (p_mode_store) else $error("mode did not store"); // [R2]

    property p_set_toggle;
        @(posedge core_clk) disable iff (rst)
            st_q == ST_PNUM && press[K_SET] && !press[K_MODE] |=> s_load_then_set;
    endproperty
    a_set_toggle: assert property (p_set_toggle) else $error("set toggle failed"); // [R3]

    property p_stopped_00;
        @(posedge core_clk) disable iff (rst)
            st_q == ST_MON && !running |=> disp2.hi == CH_ZERO && disp2.lo == CH_ZERO;
    endproperty
    a_stopped_00: assert property (p_stopped_00) else $error("stopped not 00"); // [R7]

    property p_dir;
        @(posedge core_clk) disable iff (rst)
            st_q == ST_MON && running |=> disp2.lo == ($past(dir_ccw) ? CH_F : CH_R);
    endproperty
    a_dir: assert property (p_dir) else $error("wrong direction letter"); // [R8]

    property p_pnum_range;
        @(posedge core_clk) disable iff (rst) pnum_q <= PN_MAX;
    endproperty
    a_pnum_range: assert property (p_pnum_range) else $error("parameter number out of range"); // [R12]

    property p_one_press;
        @(posedge core_clk) disable iff (rst) press[K_MODE] |=> !press[K_MODE] [*2];
    endproperty
    a_one_press: assert property (p_one_press) else $error("press repeated"); // [R19]
endmodule : kpm_top
`default_nettype wire

/* File: test/kpm_operator.sv */
// Operator model: presses keypad keys with contact bounce
`timescale 1ns/1ps
`default_nettype none
module kpm_operator #(
    parameter int DEB_N = 4
) (
    input  wire logic               core_clk,
    output var  kpm_pkg::kpm_keys_t key_raw
);
    import kpm_pkg::*;

    initial key_raw = '0;

    // Short bounce first, then a hold well past the filter, then a full release
    task automatic press(input kpm_keys_t k);
        repeat (2) @(posedge core_clk) key_raw <= k;
        @(posedge core_clk) key_raw <= '0;
        repeat (DEB_N + 8) @(posedge core_clk) key_raw <= k;
        repeat (DEB_N + 8) @(posedge core_clk) key_raw <= '0;
    endtask : press
endmodule : kpm_operator
`default_nettype wire

/* File: test/kpm_top_tb_top.sv */
// Testbench for the keypad mode controller
`timescale 1ns/1ps
`default_nettype none
module kpm_top_tb_top;
    import kpm_pkg::*;
    localparam int        DEB  = 4;
    localparam kpm_keys_t KMOD = 6'h01;
    localparam kpm_keys_t KSET = 6'h02;
    localparam kpm_keys_t KUP  = 6'h04;
    localparam kpm_keys_t KDN  = 6'h08;
    localparam kpm_keys_t KRUN = 6'h10;
    localparam kpm_keys_t KSTP = 6'h20;

    logic          core_clk;
    logic          rst;
    kpm_keys_t     key_raw;
    kpm_mon_vals_t mon;
    logic          running;
    logic          dir_ccw;
    logic          tripped;
    logic [3:0]    addr;
    logic [31:0]   wdata;
    logic          wr;
    logic          rd;
    logic [31:0]   rdata;
    logic          irq;
    logic          run_cmd;
    logic          stop_cmd;
    logic          trip_clr;
    kpm_disp5_t    disp5;
    kpm_disp2_t    disp2;
    logic          d2_flash;
    logic [31:0]   v;
    logic [15:0]   vals [5] = '{16'h0123, 16'h0456, 16'h0064, 16'h0050, 16'h0789};
    int            n_errors = 0;
    int            checks = 0;
    int            n_run = 0;
    int            n_stop = 0;
    int            n_trip = 0;

    kpm_top #(.DEB_N(DEB), .FLASH_N(8)) dut (
        .core_clk(core_clk), .rst(rst), .key_raw(key_raw), .mon(mon),
        .running(running), .dir_ccw(dir_ccw), .tripped(tripped), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .run_cmd(run_cmd), .stop_cmd(stop_cmd), .trip_clr(trip_clr),
        .disp5(disp5), .disp2(disp2), .d2_flash(d2_flash)
    );
    kpm_operator #(.DEB_N(DEB)) op (.core_clk(core_clk), .key_raw(key_raw));

    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    // Count command pulses mid-cycle, where the registered outputs have settled
    always @(negedge core_clk) begin
        if (run_cmd === 1'b1) n_run++;
        if (stop_cmd === 1'b1) n_stop++;
        if (trip_clr === 1'b1) n_trip++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("n_errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic chk_st(input logic [7:0] pn, input logic [2:0] sel, input logic [1:0] st);
        logic [31:0] s;
        rd_reg(REG_STATE, s);
        check("state", {19'h0, s[15:8], s[4:0]}, {19'h0, pn, sel, st});
    endtask : chk_st

    task automatic key(input kpm_keys_t k);
        op.press(k);
        #1;
    endtask : key

    // Lit must take both values within a few flash phases
    task automatic flash_chk;
        int n1;
        n1 = 0;
        repeat (24) begin
            @(posedge core_clk);
            #1;
            if (disp5.lit === 1'b1) n1++;
        end
        check("lit_toggles", {31'h0, n1 > 0 && n1 < 24}, 32'h1);
    endtask : flash_chk

    // Hang guard
    initial begin
        #60000;
        n_errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        mon = {vals[0], vals[1], vals[2], vals[3], vals[4]};
        {running, dir_ccw, tripped, wr, rd} = '0;
        addr = '0;
        wdata = '0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        chk_st(8'h00, 3'h0, ST_MON);
        check("disp2", {16'h0, disp2}, {16'h0, CH_ZERO, CH_ZERO});
        // Monitor cycle, each press through bounce giving exactly one step
        for (int i = 0; i < 5; i++) begin
            check("disp5", {14'h0, disp5}, {15'h0, vals[i], 1'b1});
            key(KMOD);
            chk_st(8'h00, 3'((i + 1) % 5), ST_MON);
        end
        // Panel not selected after reset: run and stop ignored
        key(KRUN);
        key(KSTP);
        check("run_stop", n_run + n_stop, 32'h0);
        rd_reg(REG_STAT, v);
        check("stat_rs", {28'h0, v[3:0]}, 32'h0);
        // Direction letters while running
        @(posedge core_clk);
        running <= 1'b1;
        dir_ccw <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check("disp2_ccw", {16'h0, disp2}, {16'h0, CH_BLANK, CH_F});
        @(posedge core_clk);
        dir_ccw <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check("disp2_cw", {16'h0, disp2}, {16'h0, CH_BLANK, CH_R});
        @(posedge core_clk);
        running <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check("disp2_stop", {16'h0, disp2}, {16'h0, CH_ZERO, CH_ZERO});
        // Parameter number mode, wrap both ways
        key(KSET);
        chk_st(8'h00, 3'h0, ST_PNUM);
        check("d2_flash", {31'h0, d2_flash}, 32'h1);
        key(KDN);
        chk_st(8'hf0, 3'h0, ST_PNUM);
        check("disp2_f0", {16'h0, disp2}, {16'h0, CH_F, CH_ZERO});
        key(KUP);
        chk_st(8'h00, 3'h0, ST_PNUM);
        key(KUP);
        check("disp2_01", {16'h0, disp2}, {16'h0, CH_ZERO, 8'h31});
        flash_chk();
        // Setting mode, store by the toggle key
        key(KSET);
        chk_st(8'h01, 3'h0, ST_SET);
        flash_chk();
        key(KUP);
        key(KSET);
        chk_st(8'h01, 3'h0, ST_PNUM);
        rd_reg(REG_STAT, v);
        check("stat_store", {28'h0, v[3:0]}, 32'h8);
        wr_reg(REG_CLR, 32'h8);
        // Store by MODE from setting mode
        key(KSET);
        key(KMOD);
        chk_st(8'h01, 3'h0, ST_MON);
        rd_reg(REG_STAT, v);
        check("stat_mode", {28'h0, v[3:0]}, 32'h8);
        wr_reg(REG_CLR, 32'h8);
        // MODE from number mode returns without a store
        key(KSET);
        key(KMOD);
        chk_st(8'h01, 3'h0, ST_MON);
        check("d2_flash_off", {31'h0, d2_flash}, 32'h0);
        rd_reg(REG_STAT, v);
        check("stat_nostore", {28'h0, v[3:0]}, 32'h0);
        // Trip clear by both arrows, then interrupt enable, mask and clear
        @(posedge core_clk);
        tripped <= 1'b1;
        key(KUP | KDN);
        check("trip_clr", n_trip, 32'h1);
        chk_st(8'h01, 3'h0, ST_MON);
        wr_reg(REG_STAT, 32'h0);
        rd_reg(REG_STAT, v);
        check("stat_trip", {28'h0, v[3:0]}, 32'h4);
        wr_reg(REG_IEN, 32'h4);
        check("irq_on", {31'h0, irq}, 32'h1);
        wr_reg(REG_IEN, 32'h0);
        check("irq_mask", {31'h0, irq}, 32'h0);
        wr_reg(REG_IEN, 32'h4);
        wr_reg(REG_CLR, 32'h4);
        @(posedge core_clk);
        #1;
        check("irq_clr", {31'h0, irq}, 32'h0);
        tripped <= 1'b0;
        rd_reg(4'h2, v);
        check("unmapped", v, 32'h0);
        // Panel source: parameter 30 set to 1, then speed factor 47 set to 2
        key(KSET);
        repeat (47) key(KUP);
        key(KSET);
        key(KUP);
        check("edit30", {15'h0, disp5.value}, 32'h1);
        key(KSET);
        repeat (23) key(KUP);
        key(KSET);
        key(KUP);
        key(KMOD);
        chk_st(8'h47, 3'h0, ST_MON);
        check("disp5_scl", {15'h0, disp5.value}, 32'h246);
        key(KRUN);
        check("run_pnl", n_run, 32'h1);
        key(KSTP);
        check("stop_pnl", n_stop, 32'h1);
        // Reset in mid-edit brings monitor mode back
        key(KSET);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        chk_st(8'h00, 3'h0, ST_MON);
        check("disp2_rst", {16'h0, disp2}, {16'h0, CH_ZERO, CH_ZERO});
        stop_test();
    end
endmodule : kpm_top_tb_top
`default_nettype wire
